// file: design/dcr_pkg.sv
package dcr_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_NUM_A_HIGH   = 8'h2f;
   localparam logic [7:0] IDX_NUM_A_LOW    = 8'h30;
   localparam logic [7:0] IDX_NUM_B_HIGH   = 8'h31;
   localparam logic [7:0] IDX_NUM_B_LOW    = 8'h32;
   localparam logic [7:0] IDX_DEN_HIGH     = 8'h33;
   localparam logic [7:0] IDX_DEN_LOW      = 8'h34;
   localparam logic [7:0] IDX_SPATIAL_HIGH = 8'h35;
   localparam logic [7:0] IDX_SPATIAL_LOW  = 8'h36;
   localparam logic [7:0] IDX_RSVD_FIRST   = 8'h37;
   localparam logic [7:0] IDX_RSVD_LAST    = 8'h40;

   // ------------------------------------------------------------
   // Storage slots and field layout
   // ------------------------------------------------------------
   localparam int unsigned NUM_SLOTS  = 8;
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned IDX_LSB    = 2;
   localparam int unsigned IDX_MSB    = 9;
   localparam logic [2:0]  SLOT_NUM_A_HIGH   = 3'h0;
   localparam logic [2:0]  SLOT_NUM_A_LOW    = 3'h1;
   localparam logic [2:0]  SLOT_NUM_B_HIGH   = 3'h2;
   localparam logic [2:0]  SLOT_NUM_B_LOW    = 3'h3;
   localparam logic [2:0]  SLOT_DEN_HIGH     = 3'h4;
   localparam logic [2:0]  SLOT_DEN_LOW      = 3'h5;
   localparam logic [2:0]  SLOT_SPATIAL_HIGH = 3'h6;
   localparam logic [2:0]  SLOT_SPATIAL_LOW  = 3'h7;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_NUM_A_HIGH   = 8'h39;
   localparam logic [7:0] RST_NUM_A_LOW    = 8'h55;
   localparam logic [7:0] RST_NUM_B_HIGH   = 8'hf3;
   localparam logic [7:0] RST_NUM_B_LOW    = 8'h2d;
   localparam logic [7:0] RST_DEN_HIGH     = 8'h53;
   localparam logic [7:0] RST_DEN_LOW      = 8'h7e;
   localparam logic [7:0] RST_SPATIAL_HIGH = 8'h7f;
   localparam logic [7:0] RST_SPATIAL_LOW  = 8'hff;
   localparam logic [7:0] RSVD_VALUE       = 8'h00;
   localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

   localparam logic [7:0][7:0] RST_BANK = {RST_SPATIAL_LOW, RST_SPATIAL_HIGH,
                                           RST_DEN_LOW,     RST_DEN_HIGH,
                                           RST_NUM_B_LOW,   RST_NUM_B_HIGH,
                                           RST_NUM_A_LOW,   RST_NUM_A_HIGH};

   // ------------------------------------------------------------
   // Bus encodings
   // ------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic signed [15:0] first_numerator_coef;
      logic signed [15:0] second_numerator_coef;
      logic signed [15:0] denominator_coef;
      logic signed [15:0] spatial_atten;
   } dcr_coefs_s;

   typedef struct packed {
      logic [7:0][7:0] bank;
      logic            wr_pend;
      logic [2:0]      wr_slot;
      logic [31:0]     rdata;
   } dcr_state_s;

endpackage : dcr_pkg

// file: design/dcr_regs.sv
// Contract
// - Each coefficient is two 8-bit registers whose concatenation is a signed 16-bit value.
// - The first numerator coefficient resets to high 0x39, low 0x55, both read/write.
// - The second numerator coefficient resets to high 0xf3, low 0x2d, both read/write.
// - The denominator coefficient resets to high 0x53, low 0x7e, both read/write.
// - The spatial attenuation coefficient resets to high 0x7f, low 0xff, both read/write.
// - Locations 0x37 to 0x40 read as zero, ignore writes, and software never writes them.
//
// Design decision made here: register access over AHB-Lite.
module dcr_regs
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   output dcr_pkg::dcr_coefs_s      coefs
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   dcr_pkg::dcr_state_s s_r;
   dcr_pkg::dcr_state_s s_nxt;
   logic                take;
   logic                map_hit;
   logic [2:0]          map_slot;
   logic [7:0]          rd_byte;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Returns {hit, slot}; misaligned or out-of-bank words miss
   function automatic logic [3:0] decode(input logic [31:0] a);
      logic [7:0] idx;
      logic       hit;
      idx = a[dcr_pkg::IDX_MSB:dcr_pkg::IDX_LSB];
      hit = (a[31:10] == 22'h00_0000) && (a[1:0] == 2'h0)
            && (idx >= dcr_pkg::IDX_NUM_A_HIGH) && (idx <= dcr_pkg::IDX_SPATIAL_LOW);
      return {hit, 3'(idx - dcr_pkg::IDX_NUM_A_HIGH)};
   endfunction : decode

   function automatic logic signed [15:0] join_coef(input logic [7:0] hi,
                                                    input logic [7:0] lo);
      return {hi, lo};
   endfunction : join_coef

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   assign take     = hsel && hready && (htrans == dcr_pkg::HTRANS_NONSEQ || htrans[1]);
   assign map_hit  = decode(haddr)[3];
   assign map_slot = decode(haddr)[2:0];

   always_comb
   begin
      s_nxt = s_r;
      // Forward a write committing now so a back-to-back read sees it
      if (!map_hit)
      begin
         rd_byte = dcr_pkg::RSVD_VALUE;
      end
      else if (s_r.wr_pend && s_r.wr_slot == map_slot)
      begin
         rd_byte = hwdata[7:0];
      end
      else
      begin
         rd_byte = s_r.bank[map_slot];
      end
      // Data phase of a write: only this byte changes
      if (s_r.wr_pend)
      begin
         s_nxt.bank[s_r.wr_slot] = hwdata[7:0];
      end
      s_nxt.wr_pend = 1'b0;
      if (take)
      begin
         if (hwrite)
         begin
            // Reserved and unmapped words drop the write
            s_nxt.wr_pend = map_hit;
            s_nxt.wr_slot = map_slot;
         end
         else
         begin
            s_nxt.rdata = {24'h00_0000, rd_byte};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r.bank    <= dcr_pkg::RST_BANK;
         s_r.wr_pend <= 1'b0;
         s_r.wr_slot <= 3'h0;
         s_r.rdata   <= dcr_pkg::RDATA_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Zero wait states, so no stall is ever needed
   assign hreadyout = 1'b1;
   assign hresp     = dcr_pkg::HRESP_OKAY;
   assign hrdata    = s_r.rdata;

   always_comb
   begin
      coefs.first_numerator_coef  = join_coef(s_r.bank[dcr_pkg::SLOT_NUM_A_HIGH],
                                              s_r.bank[dcr_pkg::SLOT_NUM_A_LOW]);
      coefs.second_numerator_coef = join_coef(s_r.bank[dcr_pkg::SLOT_NUM_B_HIGH],
                                              s_r.bank[dcr_pkg::SLOT_NUM_B_LOW]);
      coefs.denominator_coef      = join_coef(s_r.bank[dcr_pkg::SLOT_DEN_HIGH],
                                              s_r.bank[dcr_pkg::SLOT_DEN_LOW]);
      coefs.spatial_atten         = join_coef(s_r.bank[dcr_pkg::SLOT_SPATIAL_HIGH],
                                              s_r.bank[dcr_pkg::SLOT_SPATIAL_LOW]);
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Marks the first clock edge after reset release
   logic first_r;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         first_r <= 1'b1;
      end
      else
      begin
         first_r <= 1'b0;
      end
   end

   sequence wr_addr(logic [7:0] idx);
      take && hwrite && haddr == {22'h00_0000, idx, 2'h0};
   endsequence

   sequence rd_addr(logic [7:0] idx);
      take && !hwrite && haddr == {22'h00_0000, idx, 2'h0};
   endsequence

   // Ends on the edge that closes the data phase, where the byte lands
   sequence wr_commit(logic [7:0] idx);
      wr_addr(idx) ##1 1'b1;
   endsequence

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   num_a_reset_a: assert property (first_r |->
      coefs.first_numerator_coef == {dcr_pkg::RST_NUM_A_HIGH, dcr_pkg::RST_NUM_A_LOW})
      else $error("first numerator reset value wrong");

   num_b_reset_a: assert property (first_r |->
      coefs.second_numerator_coef == {dcr_pkg::RST_NUM_B_HIGH, dcr_pkg::RST_NUM_B_LOW})
      else $error("second numerator reset value wrong");

   den_reset_a: assert property (first_r |->
      coefs.denominator_coef == {dcr_pkg::RST_DEN_HIGH, dcr_pkg::RST_DEN_LOW})
      else $error("denominator reset value wrong");

   spatial_reset_a: assert property (first_r |->
      coefs.spatial_atten == {dcr_pkg::RST_SPATIAL_HIGH, dcr_pkg::RST_SPATIAL_LOW})
      else $error("attenuation reset value wrong");

   // ------------------------------------------------------------
   // Byte writes
   // ------------------------------------------------------------
   // Other half compared one edge back, so a pipelined write to
   // the partner byte just ahead cannot trip these
   high_byte_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_NUM_A_HIGH) |=>
      coefs.first_numerator_coef[15:8] == $past(hwdata[7:0])
      && coefs.first_numerator_coef[7:0] == $past(coefs.first_numerator_coef[7:0]))
      else $error("high byte write wrong or disturbed low byte");

   numa_lo_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_NUM_A_LOW) |=>
      coefs.first_numerator_coef[7:0] == $past(hwdata[7:0])
      && coefs.first_numerator_coef[15:8] == $past(coefs.first_numerator_coef[15:8]))
      else $error("first numerator low byte write wrong");

   numb_hi_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_NUM_B_HIGH) |=>
      coefs.second_numerator_coef[15:8] == $past(hwdata[7:0])
      && coefs.second_numerator_coef[7:0] == $past(coefs.second_numerator_coef[7:0]))
      else $error("second numerator high byte write wrong");

   numb_lo_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_NUM_B_LOW) |=>
      coefs.second_numerator_coef[7:0] == $past(hwdata[7:0])
      && coefs.second_numerator_coef[15:8] == $past(coefs.second_numerator_coef[15:8]))
      else $error("second numerator low byte write wrong");

   den_hi_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_DEN_HIGH) |=>
      coefs.denominator_coef[15:8] == $past(hwdata[7:0])
      && coefs.denominator_coef[7:0] == $past(coefs.denominator_coef[7:0]))
      else $error("denominator high byte write wrong");

   low_byte_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_DEN_LOW) |=>
      coefs.denominator_coef[7:0] == $past(hwdata[7:0])
      && coefs.denominator_coef[15:8] == $past(coefs.denominator_coef[15:8]))
      else $error("low byte write wrong or disturbed high byte");

   spat_hi_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_SPATIAL_HIGH) |=>
      coefs.spatial_atten[15:8] == $past(hwdata[7:0])
      && coefs.spatial_atten[7:0] == $past(coefs.spatial_atten[7:0]))
      else $error("attenuation high byte write wrong");

   spat_lo_wr_a: assert property (
      wr_commit(dcr_pkg::IDX_SPATIAL_LOW) |=>
      coefs.spatial_atten[7:0] == $past(hwdata[7:0])
      && coefs.spatial_atten[15:8] == $past(coefs.spatial_atten[15:8]))
      else $error("attenuation low byte write wrong");

   sign_bit_a: assert property (
      wr_addr(dcr_pkg::IDX_NUM_B_HIGH) ##1 hwdata[7] |=> coefs.second_numerator_coef < 0)
      else $error("negative high byte did not give a negative value");

   numa_neg_a: assert property (
      wr_commit(dcr_pkg::IDX_NUM_A_HIGH) ##0 hwdata[7] |=> coefs.first_numerator_coef < 0)
      else $error("set sign bit did not give a negative first numerator");

   numa_pos_a: assert property (
      wr_commit(dcr_pkg::IDX_NUM_A_HIGH) ##0 !hwdata[7] |=> coefs.first_numerator_coef >= 0)
      else $error("clear sign bit did not give a positive first numerator");

   idle_hold_a: assert property (!s_r.wr_pend |=> $stable(coefs))
      else $error("coefficient changed with no write landing");

   // A landing write must leave the other three coefficients alone
   numa_keep_a: assert property (
      s_r.wr_pend && s_r.wr_slot != dcr_pkg::SLOT_NUM_A_HIGH
      && s_r.wr_slot != dcr_pkg::SLOT_NUM_A_LOW |=> $stable(coefs.first_numerator_coef))
      else $error("write to another word changed the first numerator");

   numb_keep_a: assert property (
      s_r.wr_pend && s_r.wr_slot != dcr_pkg::SLOT_NUM_B_HIGH
      && s_r.wr_slot != dcr_pkg::SLOT_NUM_B_LOW |=> $stable(coefs.second_numerator_coef))
      else $error("write to another word changed the second numerator");

   den_keep_a: assert property (
      s_r.wr_pend && s_r.wr_slot != dcr_pkg::SLOT_DEN_HIGH
      && s_r.wr_slot != dcr_pkg::SLOT_DEN_LOW |=> $stable(coefs.denominator_coef))
      else $error("write to another word changed the denominator");

   spat_keep_a: assert property (
      s_r.wr_pend && s_r.wr_slot != dcr_pkg::SLOT_SPATIAL_HIGH
      && s_r.wr_slot != dcr_pkg::SLOT_SPATIAL_LOW |=> $stable(coefs.spatial_atten))
      else $error("write to another word changed the attenuation");

   // ------------------------------------------------------------
   // Reads
   // ------------------------------------------------------------
   numa_hi_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_NUM_A_HIGH) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.first_numerator_coef[15:8]})
      else $error("first numerator high byte read back wrong");

   numa_lo_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_NUM_A_LOW) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.first_numerator_coef[7:0]})
      else $error("first numerator low byte read back wrong");

   numb_hi_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_NUM_B_HIGH) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.second_numerator_coef[15:8]})
      else $error("second numerator high byte read back wrong");

   numb_lo_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_NUM_B_LOW) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.second_numerator_coef[7:0]})
      else $error("second numerator low byte read back wrong");

   den_hi_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_DEN_HIGH) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.denominator_coef[15:8]})
      else $error("denominator high byte read back wrong");

   den_lo_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_DEN_LOW) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.denominator_coef[7:0]})
      else $error("denominator low byte read back wrong");

   spat_hi_rd_a: assert property (
      rd_addr(dcr_pkg::IDX_SPATIAL_HIGH) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.spatial_atten[15:8]})
      else $error("attenuation high byte read back wrong");

   readback_a: assert property (
      rd_addr(dcr_pkg::IDX_SPATIAL_LOW) ##0 !s_r.wr_pend |=>
      hrdata == {24'h00_0000, coefs.spatial_atten[7:0]})
      else $error("read back does not match stored byte");

   // Read placed in the data phase of a write to the same word
   forward_rd_a: assert property (
      take && !hwrite && map_hit && s_r.wr_pend && s_r.wr_slot == map_slot |=>
      hrdata == {24'h00_0000, $past(hwdata[7:0])})
      else $error("read right after a write missed the new byte");

   rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");

   // ------------------------------------------------------------
   // Reserved and unmapped words
   // ------------------------------------------------------------
   rsvd_read_zero_a: assert property (
      take && !hwrite && haddr[9:2] >= dcr_pkg::IDX_RSVD_FIRST
      && haddr[9:2] <= dcr_pkg::IDX_RSVD_LAST |=> hrdata == 32'h0000_0000)
      else $error("reserved location read nonzero");

   rsvd_write_drop_a: assert property (
      take && hwrite && !map_hit |=> ##1 $stable(coefs))
      else $error("write outside bank changed a coefficient");

   off_map_rd_a: assert property (
      take && !hwrite && !map_hit |=> hrdata == 32'h0000_0000)
      else $error("read outside the bank returned nonzero");

endmodule : dcr_regs

// file: test/deemph_3d_coef_regs_tb.sv
module deemph_3d_coef_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Bench signals
   // ------------------------------------------------------------
   logic                hclk;
   logic                hresetn;
   logic                hsel;
   logic [31:0]         haddr;
   logic [1:0]          htrans;
   logic                hwrite;
   logic [2:0]          hsize;
   logic [31:0]         hwdata;
   logic                hreadyout;
   logic                hresp;
   logic [31:0]         hrdata;
   dcr_pkg::dcr_coefs_s coefs;
   logic [7:0]          model [8];
   int                  num_errors;
   int                  n_tests;

   dcr_regs dut_u
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .coefs     (coefs)
   );

   initial hclk = 1'b0;
   always #25 hclk = ~hclk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [31:0] ba(input logic [7:0] idx);
      return {22'h00_0000, idx, 2'b00};
   endfunction : ba

   // Bounded wait: a stuck slave ends the run instead of hanging it
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            num_errors++;
            tally_and_finish;
         end
         @(posedge hclk);
      end
      chk("hresp", 64'h0, {63'h0, hresp});
   endtask : wait_ready

   task automatic xfer(input logic [31:0] a, input logic wr, input logic [7:0] d,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= dcr_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= 3'h2;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      // Junk in the upper lanes: only the low byte may be stored
      hwdata <= {24'ha5a5_a5, d};
      wait_ready;
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] rd;
      xfer(a, 1'b1, d, rd);
      if (a[31:10] == 0 && a[1:0] == 0 && a[9:2] >= 8'h2f && a[9:2] <= 8'h36)
         model[int'(a[9:2] - 8'h2f)] = d;
   endtask : wr

   task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] v;
      xfer(a, 1'b0, 8'h00, v);
      chk("hrdata", {32'h0, 24'h0, e}, {32'h0, v});
   endtask : rd_chk

   task automatic chk_coefs;
      chk("coefs", {model[0], model[1], model[2], model[3],
                    model[4], model[5], model[6], model[7]}, coefs);
   endtask : chk_coefs

   task automatic chk_bank;
      int i;
      chk_coefs;
      for (i = 0; i < 8; i++)
         rd_chk(ba(8'h2f + i[7:0]), model[i]);
      for (i = 8'h37; i <= 8'h40; i++)
         rd_chk(ba(i[7:0]), 8'h00);
   endtask : chk_bank

   task automatic do_reset;
      hresetn <= 1'b0;
      hsel    <= 1'b0;
      htrans  <= 2'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      model = '{8'h39, 8'h55, 8'hf3, 8'h2d, 8'h53, 8'h7e, 8'h7f, 8'hff};
      @(posedge hclk);
   endtask : do_reset

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values;
      do_reset;
      chk_bank;
   endtask : t_reset_values

   task automatic t_each_byte;
      int i;
      for (i = 0; i < 8; i++)
      begin
         wr(ba(8'h2f + i[7:0]), 8'hc3 ^ i[7:0]);
         rd_chk(ba(8'h2f + i[7:0]), 8'hc3 ^ i[7:0]);
         chk_coefs;
      end
      chk_bank;
   endtask : t_each_byte

   task automatic t_signed_range;
      wr(ba(8'h2f), 8'h80);
      wr(ba(8'h30), 8'h00);
      // Let the byte that landed on the last edge settle before looking
      @(posedge hclk);
      chk("most negative", 64'h1, {63'h0, coefs.first_numerator_coef == -32768});
      wr(ba(8'h2f), 8'h7f);
      wr(ba(8'h30), 8'hff);
      @(posedge hclk);
      chk("most positive", 64'h1, {63'h0, coefs.first_numerator_coef == 32767});
      chk_coefs;
   endtask : t_signed_range

   // Read issued in the write's data phase must see the new byte
   task automatic t_forward;
      hsel   <= 1'b1;
      haddr  <= ba(8'h33);
      htrans <= dcr_pkg::HTRANS_NONSEQ;
      hwrite <= 1'b1;
      hsize  <= 3'h2;
      wait_ready;
      hwrite <= 1'b0;
      hwdata <= {24'h5a5a_5a, 8'h96};
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      wait_ready;
      model[4] = 8'h96;
      chk("forwarded hrdata", {32'h0, 24'h0, 8'h96}, {32'h0, hrdata});
      chk_coefs;
   endtask : t_forward

   // Reserved words are only read; off-map and misaligned writes must drop
   task automatic t_off_map;
      wr(ba(8'h2e), 8'h5a);
      wr(ba(8'h41), 8'h5a);
      wr(32'h0000_0400 | ba(8'h31), 8'h5a);
      wr(ba(8'h32) | 32'h0000_0001, 8'h5a);
      rd_chk(ba(8'h2e), 8'h00);
      chk_bank;
   endtask : t_off_map

   initial
   begin
      num_errors = 0;
      n_tests    = 0;
      hresetn    = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0000_0000;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0000_0000;
      t_reset_values;
      t_each_byte;
      t_signed_range;
      t_forward;
      t_off_map;
      t_reset_values;
      tally_and_finish;
   end

endmodule : deemph_3d_coef_regs_tb
